// *** logic/scan_result_message_assembler.sv ***
// Scan result message assembler with APB register slave
//
// Summary of operation
// [RL1] Trigger cycle ending with no good decode yields a no-read field.
// [RL2] Multi-character no-read text is sent exactly, ignoring code length.
// [RL3] Single no-read character with fixed length repeats to the fixed length.
// [RL4] Single no-read character with variable length is sent once.
// [RL5] No-read format comes only from the first enabled code type.
// [RL6] No-read text of one to 15 characters, control characters allowed.
// [RL7] Multiple codes on: every symbol in the trigger cycle is kept.
// [RL8] Multiple codes off: only the first symbol is kept, later ignored.
// [RL9] Codes go out in the order they entered the code buffer.
// [RL10] Configured separator character goes between consecutive codes.
// [RL11] Separator character X means no separator at all.
// [RL12] In multiple-code mode a failed decode adds a no-read after the last stored code.
// [RL13] Every message starts with header and ends with trailer characters.
// [RL14] Results buffered during the cycle; one message sent at cycle end.
`include "scan_result_defines.svh"

module scan_result_message_assembler #(
    parameter int BUF_DEPTH = 256
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Trigger and decoder
    input wire logic trig_start_i,
    input wire logic trig_end_i,
    input wire logic dec_valid_i,
    input wire logic [7:0] dec_data_i,
    input wire logic dec_last_i,
    input wire logic dec_fail_i,
    // Message byte stream to the serial transmitter
    output logic msg_valid_o,
    output logic [7:0] msg_data_o,
    output logic msg_last_o,
    input wire logic msg_ready_i
);
    byte_stream_if fifo_wr ();
    byte_stream_if fifo_rd ();
    byte_stream_if buf_in ();
    byte_stream_if buf_out ();

    scan_result_pkg::asm_state_t state_q;
    logic [31:0] ctrl_q;
    logic [31:0] frame_q;
    logic [3:0] nr_len_q;
    logic [31:0] nr_text_q [4];
    logic ovf_q;
    logic [7:0] msg_cnt_q;
    logic active_q;
    logic [7:0] sym_cnt_q;
    logic fail_seen_q;
    logic [7:0] left_q;
    logic noread_q;
    logic [5:0] idx_q;

    logic multi;
    logic fixed;
    logic [7:0] sep;
    logic [5:0] fix_len;
    logic [1:0] hdr_len;
    logic [1:0] trl_len;
    logic sep_on;
    logic busy;
    logic setup;
    logic mapped;
    logic take;
    logic [5:0] nr_field_len;
    logic [7:0] nr_char;
    logic [7:0] emit_data;
    logic emit_valid;
    logic unit_done;
    logic fire;
    logic final_byte;
    logic [7:0] left_after;

    assign multi = ctrl_q[`SRA_CTRL_MULTI];
    assign fixed = ctrl_q[`SRA_CTRL_FIXED];
    assign sep = ctrl_q[`SRA_CTRL_SEP_LSB +: 8];
    assign fix_len = ctrl_q[`SRA_CTRL_FIXLEN_LSB +: 6];
    // Lengths above two are clipped to the two stored characters
    assign hdr_len = (ctrl_q[`SRA_CTRL_HDRLEN_LSB +: 2] > `SRA_FRAME_MAX) ?
        `SRA_FRAME_MAX : ctrl_q[`SRA_CTRL_HDRLEN_LSB +: 2];
    assign trl_len = (ctrl_q[`SRA_CTRL_TRLLEN_LSB +: 2] > `SRA_FRAME_MAX) ?
        `SRA_FRAME_MAX : ctrl_q[`SRA_CTRL_TRLLEN_LSB +: 2];
    // [RL11] X suppresses separator
    assign sep_on = (sep != `SRA_SEP_NONE);
    assign busy = (state_q != scan_result_pkg::ST_IDLE);

    // APB: decode in setup phase, answer in the access phase with no wait
    assign setup = psel_i && !penable_i;
    assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `SRA_OFS_NR_TEXT3);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup && !mapped;
            prdata_o <= 32'h0000_0000;
            if (setup && !pwrite_i) begin
                unique case (paddr_i)
                    `SRA_OFS_CTRL: prdata_o <= ctrl_q;
                    `SRA_OFS_FRAME: prdata_o <= frame_q;
                    `SRA_OFS_STATUS: prdata_o <= {16'h0000, msg_cnt_q, 6'h00, ovf_q, busy};
                    `SRA_OFS_NR_LEN: prdata_o <= {28'h000_0000, nr_len_q};
                    default: begin
                        if (mapped) begin
                            prdata_o <= nr_text_q[paddr_i[3:2]];
                        end
                    end
                endcase
            end
        end
    end

    // Writes land at the edge that completes the access phase
    assign take = psel_i && penable_i && pwrite_i && pready_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SRA_CTRL_RESET;
            frame_q <= `SRA_FRAME_RESET;
        end else if (take && paddr_i == `SRA_OFS_CTRL) begin
            ctrl_q <= pwdata_i;
        end else if (take && paddr_i == `SRA_OFS_FRAME) begin
            frame_q <= pwdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nr_len_q <= `SRA_NR_LEN_RESET;
            for (int i = 0; i < 4; i++) begin
                nr_text_q[i] <= `SRA_NR_TEXT_RESET;
            end
        end else if (take && paddr_i == `SRA_OFS_NR_LEN) begin
            // [RL6] length held in 1..15
            nr_len_q <= (pwdata_i[3:0] == 4'h0) ? 4'h1 : pwdata_i[3:0];
        end else if (take && mapped && paddr_i >= `SRA_OFS_NR_TEXT0) begin
            // [RL6] any byte value, control characters included
            nr_text_q[paddr_i[3:2]] <= pwdata_i;
        end
    end

    // Trigger cycle tracking; a trigger edge during assembly is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_q <= 1'b0;
        end else if (trig_start_i && !busy) begin
            active_q <= 1'b1;
        end else if (trig_end_i) begin
            active_q <= 1'b0;
        end
    end

    // [RL7] all symbols kept when multi
    // [RL8] single mode drops bytes after the first symbol
    assign fifo_wr.valid = dec_valid_i && active_q && (multi || sym_cnt_q == 8'h00);
    assign fifo_wr.data = dec_data_i;
    assign fifo_wr.last = dec_last_i;

    always_ff @(posedge clk_i) begin
        if (rst_i || (trig_start_i && !busy)) begin
            sym_cnt_q <= 8'h00;
            fail_seen_q <= 1'b0;
        end else if (active_q) begin
            if (fifo_wr.valid && fifo_wr.ready && dec_last_i && sym_cnt_q != 8'hff) begin
                sym_cnt_q <= sym_cnt_q + 8'h01;
            end
            if (dec_fail_i) begin
                fail_seen_q <= 1'b1;
            end
        end
    end

    // Overflow is sticky; write one clears it, a new overflow wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (fifo_wr.valid && !fifo_wr.ready) begin
            ovf_q <= 1'b1;
        end else if (take && paddr_i == `SRA_OFS_STATUS && pwdata_i[`SRA_STAT_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    // [RL14] decoded bytes held until the trigger cycle ends
    code_fifo #(
        .DEPTH(BUF_DEPTH)
    ) u_code_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(trig_start_i && !busy),
        .wr(fifo_wr.snk),
        .rd(fifo_rd.src)
    );

    // No-read field shape
    always_comb begin
        nr_field_len = 6'd1;
        nr_char = nr_text_q[0][7:0];
        if (nr_len_q > 4'h1) begin
            // [RL2] exact text, code length ignored
            nr_field_len = {2'b00, nr_len_q};
            nr_char = nr_text_q[idx_q[3:2]][idx_q[1:0]*8 +: 8];
        end else if (fixed && fix_len != 6'd0) begin
            // [RL3] pad to fixed length
            // [RL5] fixed length is that of the first enabled code type
            nr_field_len = fix_len;
        end
        // [RL4] otherwise one copy
    end

    // Byte offered to the output buffer in each state
    always_comb begin
        emit_valid = 1'b1;
        emit_data = 8'h00;
        unit_done = 1'b0;
        unique case (state_q)
            scan_result_pkg::ST_IDLE: begin
                emit_valid = 1'b0;
            end
            scan_result_pkg::ST_HDR: begin
                emit_data = frame_q[idx_q[0]*8 +: 8];
                unit_done = (idx_q[1:0] == hdr_len - 2'd1);
            end
            scan_result_pkg::ST_CODE: begin
                // [RL9] buffer order is transmit order
                emit_valid = fifo_rd.valid;
                emit_data = fifo_rd.data;
                unit_done = fifo_rd.last;
            end
            scan_result_pkg::ST_SEP: begin
                emit_data = sep;
                unit_done = 1'b1;
            end
            scan_result_pkg::ST_NREAD: begin
                emit_data = nr_char;
                unit_done = (idx_q == nr_field_len - 6'd1);
            end
            scan_result_pkg::ST_TRL: begin
                emit_data = frame_q[16 + idx_q[0]*8 +: 8];
                unit_done = (idx_q[1:0] == trl_len - 2'd1);
            end
        endcase
    end

    assign fire = emit_valid && buf_in.ready;
    assign fifo_rd.ready = (state_q == scan_result_pkg::ST_CODE) && buf_in.ready;
    assign left_after = left_q - 8'h01;
    assign final_byte = unit_done && ((state_q == scan_result_pkg::ST_TRL) ||
        (trl_len == 2'd0 && ((state_q == scan_result_pkg::ST_NREAD) ||
        (state_q == scan_result_pkg::ST_CODE && left_q == 8'h01 && !noread_q))));

    assign buf_in.valid = emit_valid;
    assign buf_in.data = emit_data;
    assign buf_in.last = final_byte;

    // Assembly sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= scan_result_pkg::ST_IDLE;
            idx_q <= 6'd0;
            left_q <= 8'h00;
            noread_q <= 1'b0;
        end else if (state_q == scan_result_pkg::ST_IDLE) begin
            idx_q <= 6'd0;
            // [RL14] one message per trigger end
            if (active_q && trig_end_i) begin
                left_q <= sym_cnt_q;
                // [RL1] no symbol decoded
                // [RL12] a failed symbol in multi mode adds a no-read
                noread_q <= (sym_cnt_q == 8'h00) || (multi && fail_seen_q);
                // [RL13] header first
                if (hdr_len != 2'd0) begin
                    state_q <= scan_result_pkg::ST_HDR;
                end else if (sym_cnt_q != 8'h00) begin
                    state_q <= scan_result_pkg::ST_CODE;
                end else begin
                    state_q <= scan_result_pkg::ST_NREAD;
                end
            end
        end else if (fire) begin
            idx_q <= unit_done ? 6'd0 : idx_q + 6'd1;
            if (unit_done) begin
                unique case (state_q)
                    scan_result_pkg::ST_HDR: begin
                        state_q <= (left_q != 8'h00) ? scan_result_pkg::ST_CODE :
                            scan_result_pkg::ST_NREAD;
                    end
                    scan_result_pkg::ST_CODE: begin
                        left_q <= left_after;
                        // [RL10] separator between codes
                        if (left_after != 8'h00 || noread_q) begin
                            state_q <= sep_on ? scan_result_pkg::ST_SEP :
                                (left_after != 8'h00) ? scan_result_pkg::ST_CODE :
                                scan_result_pkg::ST_NREAD;
                        end else begin
                            state_q <= (trl_len != 2'd0) ? scan_result_pkg::ST_TRL :
                                scan_result_pkg::ST_IDLE;
                        end
                    end
                    scan_result_pkg::ST_SEP: begin
                        // [RL12] no-read after the last code
                        state_q <= (left_q != 8'h00) ? scan_result_pkg::ST_CODE :
                            scan_result_pkg::ST_NREAD;
                    end
                    scan_result_pkg::ST_NREAD: begin
                        state_q <= (trl_len != 2'd0) ? scan_result_pkg::ST_TRL :
                            scan_result_pkg::ST_IDLE;
                    end
                    default: begin
                        // [RL13] trailer closes the message
                        state_q <= scan_result_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_cnt_q <= 8'h00;
        end else if (fire && final_byte) begin
            msg_cnt_q <= msg_cnt_q + 8'h01;
        end
    end

    two_entry_buffer u_out_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in(buf_in.snk),
        .out(buf_out.src)
    );

    assign buf_out.ready = msg_ready_i;
    assign msg_valid_o = buf_out.valid;
    assign msg_data_o = buf_out.data;
    assign msg_last_o = buf_out.last;
endmodule

// *** logic/scan_result_defines.svh ***
// Register offsets, field positions, reset values and limits of the result message assembler
`ifndef SCAN_RESULT_DEFINES_SVH
`define SCAN_RESULT_DEFINES_SVH

`define SRA_OFS_CTRL 8'h00
`define SRA_OFS_FRAME 8'h04
`define SRA_OFS_STATUS 8'h08
`define SRA_OFS_NR_LEN 8'h0c
`define SRA_OFS_NR_TEXT0 8'h10
`define SRA_OFS_NR_TEXT3 8'h1c

`define SRA_CTRL_MULTI 0
`define SRA_CTRL_FIXED 1
`define SRA_CTRL_SEP_LSB 8
`define SRA_CTRL_FIXLEN_LSB 16
`define SRA_CTRL_HDRLEN_LSB 24
`define SRA_CTRL_TRLLEN_LSB 28

`define SRA_STAT_BUSY 0
`define SRA_STAT_OVF 1
`define SRA_STAT_CNT_LSB 8

`define SRA_CTRL_RESET 32'h0000_2d00
`define SRA_FRAME_RESET 32'h0000_0000
`define SRA_NR_LEN_RESET 4'h1
`define SRA_NR_TEXT_RESET 32'h0000_003f

`define SRA_SEP_NONE 8'h58
`define SRA_NR_MAX 4'hf
`define SRA_FRAME_MAX 2'h2

`endif

// *** logic/scan_result_pkg.sv ***
// Types shared by the result message assembler
package scan_result_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_CODE = 3'b010,
        ST_SEP = 3'b011,
        ST_NREAD = 3'b100,
        ST_TRL = 3'b101
    } asm_state_t;

endpackage

// *** logic/byte_stream_if.sv ***
// Byte stream with valid, ready and end-of-unit marker
interface byte_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    logic last;

    modport src (output valid, output data, output last, input ready);
    modport snk (input valid, input data, input last, output ready);
endinterface

// *** logic/code_fifo.sv ***
// Code buffer: decoded bytes of one trigger cycle, kept in arrival order
module code_fifo #(
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // Streams
    byte_stream_if.snk wr,
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [8:0] mem [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic full;
    logic empty;

    assign empty = (wptr_q == rptr_q);
    assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_q[AW-1:0]][7:0];
    assign rd.last = mem[rptr_q[AW-1:0]][8];

    always_ff @(posedge clk_i) begin
        if (wr.valid && !full) begin
            mem[wptr_q[AW-1:0]] <= {wr.last, wr.data};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wptr_q <= '0;
        end else if (wr.valid && !full) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            rptr_q <= '0;
        end else if (rd.ready && !empty) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end
endmodule

// *** logic/two_entry_buffer.sv ***
// Two-entry output buffer; ready toward the source is registered
module two_entry_buffer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Streams
    byte_stream_if.snk in,
    byte_stream_if.src out
);
    logic main_v_q;
    logic [8:0] main_q;
    logic skid_v_q;
    logic [8:0] skid_q;
    logic in_fire;

    assign in.ready = !skid_v_q;
    assign in_fire = in.valid && !skid_v_q;
    assign out.valid = main_v_q;
    assign out.data = main_q[7:0];
    assign out.last = main_q[8];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_v_q <= 1'b0;
            main_q <= 9'h000;
            skid_v_q <= 1'b0;
            skid_q <= 9'h000;
        end else if (!main_v_q || out.ready) begin
            if (skid_v_q) begin
                main_q <= skid_q;
                skid_v_q <= 1'b0;
            end else begin
                main_v_q <= in_fire;
                if (in_fire) begin
                    main_q <= {in.last, in.data};
                end
            end
        end else if (in_fire) begin
            // Receiver stalled: park the word so nothing is lost
            skid_q <= {in.last, in.data};
            skid_v_q <= 1'b1;
        end
    end
endmodule

// *** verification/scan_result_message_assembler_chk.sv ***
// Port checks on the result message assembler
module scan_result_message_assembler_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Trigger and decoder
    input wire logic trig_start_i,
    input wire logic trig_end_i,
    input wire logic dec_valid_i,
    input wire logic [7:0] dec_data_i,
    input wire logic dec_last_i,
    input wire logic dec_fail_i,
    // Message stream
    input wire logic msg_valid_o,
    input wire logic [7:0] msg_data_o,
    input wire logic msg_last_o,
    input wire logic msg_ready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_setup_ready;
        psel_i && !penable_i |=> pready_o && psel_i && penable_i;
    endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("no ready in access cycle");
    property p_ready_once;
        pready_o |=> !pready_o;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("ready stands longer than one cycle");
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("error without ready");
    property p_rdata_idle;
        !pready_o |-> prdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside access cycle");
    property p_unmapped;
        psel_i && !penable_i && (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0)
            |=> pslverr_o && prdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_mapped;
        psel_i && !penable_i && paddr_i <= 8'h1c && paddr_i[1:0] == 2'h0 |=> !pslverr_o;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access refused");
    property p_reset_quiet;
        $fell(rst_i) |-> !msg_valid_o && !msg_last_o && !pready_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_msg_hold;
        msg_valid_o && !msg_ready_i
            |=> msg_valid_o && $stable(msg_data_o) && $stable(msg_last_o);
    endproperty
    a_msg_hold: assert property (p_msg_hold)
        else $error("stalled message byte changed");
endmodule

// *** verification/host_msg_sink.sv ***
// Host side model that takes message bytes, slowly on request
module host_msg_sink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // Message stream
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic last_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int n_msg = 0;
    logic [1:0] ph_q = 2'h0;
    // A slow host takes one byte in four, so the output buffer backs up
    assign ready_o = !slow_i || (ph_q == 2'h3);
    always @(posedge clk_i) begin
        ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
        if (!rst_i && valid_i && ready_o) begin
            got.push_back(data_i);
            if (last_i)
                n_msg <= n_msg + 1;
        end
    end
endmodule

// *** verification/scan_result_message_assembler_tb_top.sv ***
// Testbench for the result message assembler
`include "scan_result_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module scan_result_message_assembler_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic trig_start_i = 1'b0, trig_end_i = 1'b0, dec_valid_i = 1'b0;
    logic dec_last_i = 1'b0, dec_fail_i = 1'b0, msg_valid_o, msg_last_o, msg_ready_i;
    logic [7:0] dec_data_i = 8'h00, msg_data_o;
    int failures = 0;
    int n_compared = 0;

    always #50 clk_i = ~clk_i;

    scan_result_message_assembler #(.BUF_DEPTH(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .trig_start_i(trig_start_i), .trig_end_i(trig_end_i), .dec_valid_i(dec_valid_i),
        .dec_data_i(dec_data_i), .dec_last_i(dec_last_i), .dec_fail_i(dec_fail_i),
        .msg_valid_o(msg_valid_o), .msg_data_o(msg_data_o), .msg_last_o(msg_last_o),
        .msg_ready_i(msg_ready_i));
    host_msg_sink i_host (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(msg_valid_o),
        .data_i(msg_data_o), .last_i(msg_last_o), .ready_o(msg_ready_i));

    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge, released at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1)
            failures++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        `CHK(rd, exp)
        `CHK(err, experr)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        `CHK(err, 1'b0)
    endtask

    function automatic logic [31:0] ctl(input logic m, input logic f, input logic [7:0] sep,
                                        input logic [5:0] len);
        return 32'h2100_0000 | {10'h000, len, sep, 6'h00, f, m};
    endfunction

    task automatic sym(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_i);
            dec_valid_i <= 1'b1;
            dec_data_i <= s[i];
            dec_last_i <= (i == s.len() - 1);
        end
        @(posedge clk_i);
        dec_valid_i <= 1'b0;
        dec_last_i <= 1'b0;
    endtask

    // One trigger cycle; the message is framed by one header and two trailer bytes
    task automatic trig(input string a, input string b, input bit fail, input string exp);
        logic [7:0] e[$];
        int n0;
        int n = 0;
        i_host.got.delete();
        n0 = i_host.n_msg;
        @(posedge clk_i);
        trig_start_i <= 1'b1;
        @(posedge clk_i);
        trig_start_i <= 1'b0;
        sym(a);
        sym(b);
        dec_fail_i <= fail;
        @(posedge clk_i);
        dec_fail_i <= 1'b0;
        trig_end_i <= 1'b1;
        @(posedge clk_i);
        trig_end_i <= 1'b0;
        while (i_host.n_msg == n0 && n < 400) begin
            n++;
            @(negedge clk_i);
        end
        repeat (20) @(negedge clk_i);
        e.push_back(8'h02);
        for (int i = 0; i < exp.len(); i++)
            e.push_back(exp[i]);
        e.push_back(8'h0d);
        e.push_back(8'h0a);
        `CHK(i_host.n_msg, n0 + 1)
        `CHK(i_host.got.size(), e.size())
        foreach (e[i])
            if (i < i_host.got.size())
                `CHK(i_host.got[i], e[i])
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic err;
        rd_chk(`SRA_OFS_CTRL, `SRA_CTRL_RESET, 1'b0);
        rd_chk(`SRA_OFS_NR_LEN, 32'h0000_0001, 1'b0);
        rd_chk(`SRA_OFS_NR_TEXT3, `SRA_NR_TEXT_RESET, 1'b0);
        rd_chk(8'h20, 32'h0, 1'b1);
        apb(1'b1, 8'h02, 32'hffff_ffff, rd, err);
        `CHK(err, 1'b1)
        wr(`SRA_OFS_NR_LEN, 32'h0000_000f);
        rd_chk(`SRA_OFS_NR_LEN, 32'h0000_000f, 1'b0);
        wr(`SRA_OFS_NR_LEN, 32'h0);
        rd_chk(`SRA_OFS_NR_LEN, 32'h0000_0001, 1'b0);
        wr(`SRA_OFS_FRAME, 32'h0a0d_0002);
    endtask

    task automatic t_nr_text();
        wr(`SRA_OFS_NR_LEN, 32'h0000_0007);
        wr(`SRA_OFS_NR_TEXT0, 32'h5220_4f4e);
        wr(8'h14, 32'h0044_4145);
        wr(`SRA_OFS_CTRL, ctl(1'b0, 1'b1, 8'h2d, 6'h04));
        trig("", "", 1'b0, "NO READ");
    endtask

    task automatic t_nr_single();
        wr(`SRA_OFS_NR_LEN, 32'h0000_0001);
        wr(`SRA_OFS_NR_TEXT0, 32'h0000_0023);
        wr(`SRA_OFS_CTRL, ctl(1'b0, 1'b1, 8'h2d, 6'h05));
        trig("", "", 1'b1, "#####");
        wr(`SRA_OFS_CTRL, ctl(1'b0, 1'b0, 8'h2d, 6'h05));
        trig("", "", 1'b0, "#");
    endtask

    task automatic t_multi();
        slow <= 1'b1;
        wr(`SRA_OFS_CTRL, ctl(1'b1, 1'b0, 8'h2a, 6'h00));
        trig("AB", "C", 1'b1, "AB*C*#");
        slow <= 1'b0;
        wr(`SRA_OFS_CTRL, ctl(1'b1, 1'b0, `SRA_SEP_NONE, 6'h00));
        trig("AB", "C", 1'b0, "ABC");
        wr(`SRA_OFS_CTRL, ctl(1'b0, 1'b0, 8'h2a, 6'h00));
        trig("AB", "CD", 1'b0, "AB");
        // Six messages sent so far, idle, no overflow
        rd_chk(`SRA_OFS_STATUS, 32'h0000_0600, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_nr_text();
        t_nr_single();
        t_multi();
        stop_test();
    end

    // The whole sequence needs a few hundred cycles
    initial begin
        #3000000;
        failures++;
        stop_test();
    end
endmodule

bind scan_result_message_assembler scan_result_message_assembler_chk i_chk (.clk_i(clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .trig_start_i(trig_start_i), .trig_end_i(trig_end_i),
    .dec_valid_i(dec_valid_i), .dec_data_i(dec_data_i), .dec_last_i(dec_last_i),
    .dec_fail_i(dec_fail_i), .msg_valid_o(msg_valid_o), .msg_data_o(msg_data_o),
    .msg_last_o(msg_last_o), .msg_ready_i(msg_ready_i));
